/* File: hdl/quad_dac_consts.vh */
// Purpose: shared constants of the quad converter control block
// Assumes: included by bare name from the design files
// Notes: byte offsets are word aligned on a 32-bit bus
`ifndef QUAD_DAC_CONSTS_VH
`define QUAD_DAC_CONSTS_VH

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define FRAME_BITS 16
`define FRAME_LAST_EDGE 5'h10
`define FRAME_SEL_HI 15
`define FRAME_SEL_LO 14
`define FRAME_OP_HI 13
`define FRAME_OP_LO 12
`define FRAME_CODE_HI 11
`define FRAME_CODE_LO 2
`define CODE_BITS 10
`define CODE_ZERO 10'h000

// ----------------------------------------------------------------
// operation modes
// ----------------------------------------------------------------
`define OP_WRITE_HOLD 2'h0
`define OP_WRITE_UPDATE 2'h1
`define OP_WRITE_ALL 2'h2
`define OP_POWER_DOWN 2'h3

// ----------------------------------------------------------------
// power-down terminations (channel select field)
// ----------------------------------------------------------------
`define TERM_HIZ_A 2'h0
`define TERM_2K5 2'h1
`define TERM_100K 2'h2
`define TERM_HIZ_B 2'h3

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define REG_CTRL 32'h0000_0000
`define REG_STATUS 32'h0000_0004
`define REG_CMD 32'h0000_0008
`define REG_CHAN0 32'h0000_0010
`define REG_CHAN1 32'h0000_0014
`define REG_CHAN2 32'h0000_0018
`define REG_CHAN3 32'h0000_001C
`define IDX_NONE 3'h7
`define IDX_CTRL 3'h0
`define IDX_STATUS 3'h1
`define IDX_CMD 3'h2
`define IDX_CHAN0 3'h4
`define CTRL_RESET 1'h1
`define CTRL_SERIAL_EN 0
`define CHAN_OUT_LO 16
`define HRESP_OKAY 1'h0

`endif

/* File: hdl/frame_shifter.v */
// Purpose: collect 16-bit frames from the three-wire serial port
// Assumes: frame select, serial clock and data synchronous to clk
// Notes: serial clock must be slower than clk/2 for edge detection
`timescale 1ns/100ps
`include "quad_dac_consts.vh"

module frame_shifter
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial pins
  input wire syncN,
  input wire sclk,
  input wire din,
  // frame out
  output reg frameValid,
  output reg [15:0] frameWord
);

  reg sclkPrev;
  reg [4:0] edgeCount;
  reg [15:0] shift;
  wire fallEdge;

  // ----------------------------------------------------------------
  // shift on falling serial clock while frame select is low
  // ----------------------------------------------------------------
  assign fallEdge = sclkPrev & ~sclk & ~syncN;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sclkPrev <= 1'b0;
      edgeCount <= 5'h00;
      shift <= 16'h0000;
      frameValid <= 1'b0;
      frameWord <= 16'h0000;
    end
    else
    begin
      sclkPrev <= sclk;
      frameValid <= 1'b0;
      if (syncN)
      begin
        // short frame simply lost: nothing below ever saw it
        edgeCount <= 5'h00;
      end
      else if (fallEdge && edgeCount != `FRAME_LAST_EDGE)
      begin
        shift <= {shift[14:0], din};
        edgeCount <= edgeCount + 5'h01;
        if (edgeCount == `FRAME_LAST_EDGE - 5'h01)
        begin
          // further clocks ignored until frame select rises
          frameValid <= 1'b1;
          frameWord <= {shift[14:0], din};
        end
      end
    end
  end

endmodule

/* File: hdl/quad_dac_power_control.v */
// Purpose: command decode, channel registers and power-down control
// Assumes: one clock, synchronous active-low reset standing for power-on
// Notes: registers reachable over AHB-Lite, zero wait states
//
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "quad_dac_consts.vh"

module quad_dac_power_control
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial pins
  input wire syncN,
  input wire sclk,
  input wire din,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // converter outputs
  output reg [9:0] outCode0,
  output reg [9:0] outCode1,
  output reg [9:0] outCode2,
  output reg [9:0] outCode3,
  output reg powerDown,
  output reg outHighZ,
  output reg term2k5,
  output reg term100k,
  output reg analogShutdown
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wire serialValid;
  wire [15:0] serialWord;
  reg [9:0] chanReg [0:3];
  reg [9:0] liveCode [0:3];
  reg started;
  reg pdActive;
  reg [1:0] pdTerm;
  reg serialEnable;
  reg cmdPending;
  reg [15:0] cmdWord;
  reg [31:0] frameCount;
  reg dpWrite;
  reg [2:0] dpIndex;
  reg execValid;
  reg [15:0] execWord;
  wire [1:0] channel_select_bit_pair;
  wire channel_select_bit_high;
  wire channel_select_bit_low;
  wire op_mode_bit_high;
  wire op_mode_bit_low;
  wire [1:0] opMode;
  wire [9:0] newCode;
  wire addrPhase;
  wire busWriteCmd;
  integer i;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [2:0] busIndex;
    input [31:0] addr;
    begin
      case (addr)
        `REG_CTRL: busIndex = `IDX_CTRL;
        `REG_STATUS: busIndex = `IDX_STATUS;
        `REG_CMD: busIndex = `IDX_CMD;
        `REG_CHAN0: busIndex = `IDX_CHAN0;
        `REG_CHAN1: busIndex = `IDX_CHAN0 + 3'h1;
        `REG_CHAN2: busIndex = `IDX_CHAN0 + 3'h2;
        `REG_CHAN3: busIndex = `IDX_CHAN0 + 3'h3;
        default: busIndex = `IDX_NONE;
      endcase
    end
  endfunction

  function isHighZ;
    input [1:0] sel;
    begin
      isHighZ = (sel == `TERM_HIZ_A) || (sel == `TERM_HIZ_B);
    end
  endfunction

  // ----------------------------------------------------------------
  // serial front end
  // ----------------------------------------------------------------
  frame_shifter shifter
  (
    .clk(clk),
    .rst_n(rst_n),
    .syncN(syncN),
    .sclk(sclk),
    .din(din),
    .frameValid(serialValid),
    .frameWord(serialWord)
  );

  // ----------------------------------------------------------------
  // command source select
  // ----------------------------------------------------------------
  // serial frame wins a collision; the bus command waits a cycle
  always @*
  begin
    execValid = 1'b0;
    execWord = cmdWord;
    if (serialValid && serialEnable)
    begin
      execValid = 1'b1;
      execWord = serialWord;
    end
    else if (cmdPending)
    begin
      execValid = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  assign channel_select_bit_high = execWord[`FRAME_SEL_HI];
  assign channel_select_bit_low = execWord[`FRAME_SEL_LO];
  assign op_mode_bit_high = execWord[`FRAME_OP_HI];
  assign op_mode_bit_low = execWord[`FRAME_OP_LO];
  assign channel_select_bit_pair = {channel_select_bit_high, channel_select_bit_low};
  assign opMode = {op_mode_bit_high, op_mode_bit_low};
  // two lowest data bits carry no weight at this resolution
  assign newCode = execWord[`FRAME_CODE_HI:`FRAME_CODE_LO];

  // ----------------------------------------------------------------
  // channel registers and mode
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        chanReg[i] <= `CODE_ZERO;
        liveCode[i] <= `CODE_ZERO;
      end
      started <= 1'b0;
      pdActive <= 1'b0;
      pdTerm <= `TERM_HIZ_A;
      frameCount <= 32'h0000_0000;
    end
    else if (execValid)
    begin
      started <= 1'b1;
      frameCount <= frameCount + 32'h0000_0001;
      case (opMode)
        `OP_WRITE_HOLD:
        begin
          chanReg[channel_select_bit_pair] <= newCode;
          pdActive <= 1'b0;
        end
        `OP_WRITE_UPDATE:
        begin
          for (i = 0; i < 4; i = i + 1)
          begin
            liveCode[i] <= (i == channel_select_bit_pair) ? newCode : chanReg[i];
          end
          chanReg[channel_select_bit_pair] <= newCode;
          pdActive <= 1'b0;
        end
        `OP_WRITE_ALL:
        begin
          for (i = 0; i < 4; i = i + 1)
          begin
            chanReg[i] <= newCode;
            liveCode[i] <= newCode;
          end
          pdActive <= 1'b0;
        end
        `OP_POWER_DOWN:
        begin
          // select bits name a termination here, not a channel
          pdActive <= 1'b1;
          pdTerm <= channel_select_bit_pair;
          // channel registers deliberately left alone
        end
        default:
        begin
          pdActive <= pdActive;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter outputs
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      outCode0 <= `CODE_ZERO;
      outCode1 <= `CODE_ZERO;
      outCode2 <= `CODE_ZERO;
      outCode3 <= `CODE_ZERO;
      powerDown <= 1'b0;
      outHighZ <= 1'b0;
      term2k5 <= 1'b0;
      term100k <= 1'b0;
      analogShutdown <= 1'b0;
    end
    else
    begin
      // zero until a valid frame, and zero while powered down
      outCode0 <= (started && !pdActive) ? liveCode[0] : `CODE_ZERO;
      outCode1 <= (started && !pdActive) ? liveCode[1] : `CODE_ZERO;
      outCode2 <= (started && !pdActive) ? liveCode[2] : `CODE_ZERO;
      outCode3 <= (started && !pdActive) ? liveCode[3] : `CODE_ZERO;
      powerDown <= pdActive;
      analogShutdown <= pdActive;
      outHighZ <= pdActive && isHighZ(pdTerm);
      term2k5 <= pdActive && (pdTerm == `TERM_2K5);
      term100k <= pdActive && (pdTerm == `TERM_100K);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign addrPhase = hsel && htrans[1] && hready;
  assign busWriteCmd = dpWrite && (dpIndex == `IDX_CMD);

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      dpWrite <= 1'b0;
      dpIndex <= `IDX_NONE;
      serialEnable <= `CTRL_RESET;
      cmdPending <= 1'b0;
      cmdWord <= 16'h0000;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= `HRESP_OKAY;
      dpWrite <= addrPhase && hwrite;
      dpIndex <= addrPhase ? busIndex(haddr) : `IDX_NONE;
      // data phase writes
      if (dpWrite && dpIndex == `IDX_CTRL)
      begin
        serialEnable <= hwdata[`CTRL_SERIAL_EN];
      end
      // a new command wins over the retire of an older one
      if (busWriteCmd)
      begin
        cmdWord <= hwdata[15:0];
        cmdPending <= 1'b1;
      end
      else if (cmdPending && !(serialValid && serialEnable))
      begin
        cmdPending <= 1'b0;
      end
      // read data prepared at address phase, stands through data phase
      if (addrPhase && !hwrite)
      begin
        case (busIndex(haddr))
          `IDX_CTRL: hrdata <= {31'h0000_0000, serialEnable};
          `IDX_STATUS: hrdata <= {24'h00_0000, frameCount[3:0], cmdPending,
                                  pdTerm, pdActive} | {27'h000_0000, started, 4'h0};
          `IDX_CMD: hrdata <= {16'h0000, cmdWord};
          `IDX_CHAN0: hrdata <= {6'h00, liveCode[0], 6'h00, chanReg[0]};
          `IDX_CHAN0 + 3'h1: hrdata <= {6'h00, liveCode[1], 6'h00, chanReg[1]};
          `IDX_CHAN0 + 3'h2: hrdata <= {6'h00, liveCode[2], 6'h00, chanReg[2]};
          `IDX_CHAN0 + 3'h3: hrdata <= {6'h00, liveCode[3], 6'h00, chanReg[3]};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

/* File: sim/quad_dac_power_control_sva.sv */
// Purpose: port checker for the quad converter control
// Assumes: one clock, synchronous active-low reset
// Notes: shadows the serial shifter to learn each frame
`timescale 1ns/100ps
module quad_dac_power_control_chk
(
  // clock and reset
  input wire clk,
  input wire rst_n,
  // serial pins
  input wire syncN,
  input wire sclk,
  input wire din,
  // converter outputs
  input wire [9:0] outCode0,
  input wire [9:0] outCode1,
  input wire [9:0] outCode2,
  input wire [9:0] outCode3,
  input wire powerDown,
  input wire outHighZ,
  input wire term2k5,
  input wire term100k,
  input wire analogShutdown
);
  reg prevSclk;
  reg [4:0] fallCnt;
  reg [15:0] shadow;
  reg [1:0] lastSel;
  wire fall = prevSclk && !sclk && !syncN;
  wire last = fall && fallCnt == 5'h0F;
  wire [15:0] word = {shadow[14:0], din};
  wire [39:0] codes = {outCode0, outCode1, outCode2, outCode3};
  // ------------
  // frame shadow
  // ------------
  // count saturates so falls after the sixteenth never look like a new frame
  always @(posedge clk)
  begin
    prevSclk <= rst_n && sclk;
    if (!rst_n || syncN)
      fallCnt <= 5'h00;
    else if (fall && fallCnt != 5'h10)
      fallCnt <= fallCnt + 5'h01;
    if (fall)
      shadow <= word;
    if (last)
      lastSel <= word[15:14];
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence pdCmd;
    last && word[13:12] == 2'h3;
  endsequence
  sequence wrCmd;
    last && word[13:12] != 2'h3;
  endsequence
  sequence abortFrame;
    $rose(syncN) && fallCnt != 5'h00 && fallCnt < 5'h10;
  endsequence
  AST_SHUT: assert property (analogShutdown == powerDown)
    else $error("shutdown differs from power-down");
  AST_HIZ: assert property (outHighZ |-> powerDown && !term2k5 && !term100k)
    else $error("high impedance outside power-down");
  AST_ONEHOT: assert property (powerDown |-> $onehot({outHighZ, term2k5, term100k}))
    else $error("not exactly one termination");
  AST_PD_ZERO: assert property (powerDown |-> codes == 40'h00_0000_0000)
    else $error("codes not zero in power-down");
  AST_RESET: assert property ($rose(rst_n) |-> codes == 40'h00_0000_0000 && !powerDown)
    else $error("outputs not cleared by reset");
  AST_ABORT: assert property (abortFrame |-> ##1 ($stable(codes) && $stable(powerDown)) [*6])
    else $error("short frame changed outputs");
  AST_PD_TERM: assert property (pdCmd |-> ##[1:5] (powerDown && term2k5 == (lastSel == 2'h1) && term100k == (lastSel == 2'h2)))
    else $error("power-down command not applied");
  AST_WAKE: assert property (wrCmd |-> ##[1:5] !powerDown)
    else $error("write frame did not leave power-down");
endmodule

/* File: sim/host_serial_model.sv */
// Purpose: host serial master driving the frame port
// Assumes: frame port sampled on clk; sclk half period of two clk
// Notes: clock idles low and stops between frames
`timescale 1ns/100ps
module host_serial_model
(
  // clock
  input wire clk,
  // serial pins
  output reg syncN,
  output reg sclk,
  output reg din
);
  integer k;
  initial
  begin
    syncN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // ----------
  // frame send
  // ----------
  // select held low over the whole word; bits past sixteen are junk
  task send(input [15:0] w, input integer n);
    begin
      syncN <= 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; k < n; k = k + 1)
      begin
        sclk <= 1'b1;
        din <= (k < 16) ? w[15 - k] : ~din;
        repeat (2) @(posedge clk);
        sclk <= 1'b0;
        repeat (2) @(posedge clk);
      end
      syncN <= 1'b1;
      din <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule

/* File: sim/tb_top.sv */
// Purpose: self-checking bench for the quad converter control
// Assumes: host model drives the serial pins
// Notes: expected codes are data bits 11:2 of each frame
`timescale 1ns/100ps
`include "quad_dac_consts.vh"
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [31:0] rd;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [9:0] outCode0;
  wire [9:0] outCode1;
  wire [9:0] outCode2;
  wire [9:0] outCode3;
  wire powerDown;
  wire outHighZ;
  wire term2k5;
  wire term100k;
  wire analogShutdown;
  wire syncN;
  wire sclk;
  wire din;
  wire [4:0] pdv = {powerDown, analogShutdown, outHighZ, term2k5, term100k};
  integer n_errors = 0;
  integer checks_done = 0;
  integer s;
  always #2.5 clk = ~clk;
  host_serial_model host_serial_model_i (.clk(clk), .syncN(syncN), .sclk(sclk), .din(din));
  quad_dac_power_control quad_dac_power_control_i
  (
    .clk(clk), .rst_n(rst_n), .syncN(syncN), .sclk(sclk), .din(din), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .outCode0(outCode0), .outCode1(outCode1), .outCode2(outCode2), .outCode3(outCode3),
    .powerDown(powerDown), .outHighZ(outHighZ), .term2k5(term2k5), .term100k(term100k),
    .analogShutdown(analogShutdown)
  );
  // -----
  // tasks
  // -----
  task chk(input [39:0] seen, input [39:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task outs(input [39:0] e);
    chk({outCode0, outCode1, outCode2, outCode3}, e);
  endtask
  task ahb(input wr, input [31:0] a, input [31:0] wd, output [31:0] r);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1)
        @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1)
        @(posedge clk);
      r = hrdata;
      chk({39'h0, hresp}, 40'h00_0000_0000);
    end
  endtask
  task rdk(input [31:0] a, input [31:0] m, input [31:0] e);
    begin
      ahb(1'b0, a, 32'h0000_0000, rd);
      chk({8'h00, rd & m}, {8'h00, e});
    end
  endtask
  task frm(input [15:0] w, input integer n);
    begin
      host_serial_model_i.send(w, n);
      repeat (4) @(posedge clk);
    end
  endtask
  task summarize;
    begin
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    outs(40'h00_0000_0000);
    rdk(`REG_CHAN0, 32'h0000_03FF, 32'h0000_0000);
    rdk(`REG_CTRL, 32'h0000_0001, 32'h0000_0001);
    rdk(32'h0000_0040, 32'hFFFF_FFFF, 32'h0000_0000);
    frm(16'h2ABC, 16);
    outs({4{10'h2AF}});
    frm(16'h4004, 18);
    outs({4{10'h2AF}});
    frm(16'h9FFC, 16);
    outs({10'h2AF, 10'h001, 10'h3FF, 10'h2AF});
    frm(16'h2000, 10);
    outs({10'h2AF, 10'h001, 10'h3FF, 10'h2AF});
    // serial port disabled: a full frame must leave everything alone
    ahb(1'b1, `REG_CTRL, 32'h0000_0000, rd);
    frm(16'h2000, 16);
    outs({10'h2AF, 10'h001, 10'h3FF, 10'h2AF});
    ahb(1'b1, `REG_CTRL, 32'h0000_0001, rd);
    for (s = 0; s < 4; s = s + 1)
    begin
      frm({s[1:0], 14'h3000}, 16);
      chk({35'h0, pdv}, {35'h0, 2'h3, s == 0 || s == 3, s == 1, s == 2});
      outs(40'h00_0000_0000);
      rdk(`REG_CHAN1, 32'h0000_03FF, 32'h0000_0001);
      rdk(`REG_STATUS, 32'h0000_0007, {29'h0000_0000, s[1:0], 1'b1});
    end
    frm(16'h0010, 16);
    chk({35'h0, pdv}, 40'h00_0000_0000);
    outs({10'h2AF, 10'h001, 10'h3FF, 10'h2AF});
    rdk(`REG_CHAN0, 32'h0000_03FF, 32'h0000_0004);
    // bus command: select 11, write and update all, code 2
    ahb(1'b1, `REG_CMD, 32'h0000_D008, rd);
    repeat (4) @(posedge clk);
    outs({10'h004, 10'h001, 10'h3FF, 10'h002});
    rdk(`REG_CMD, 32'h0000_FFFF, 32'h0000_D008);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    outs(40'h00_0000_0000);
    rdk(`REG_CHAN3, 32'h03FF_03FF, 32'h0000_0000);
    summarize;
  end
  initial
  begin
    #50000;
    n_errors = n_errors + 1;
    summarize;
  end
endmodule
bind quad_dac_power_control quad_dac_power_control_chk quad_dac_power_control_chk_i
(
  .clk(clk), .rst_n(rst_n), .syncN(syncN), .sclk(sclk), .din(din),
  .outCode0(outCode0), .outCode1(outCode1), .outCode2(outCode2), .outCode3(outCode3),
  .powerDown(powerDown), .outHighZ(outHighZ), .term2k5(term2k5), .term100k(term100k),
  .analogShutdown(analogShutdown)
);
